// File: hw/pbal_aux_lines.sv
`timescale 1ns/1ns
`include "pbal_regs.svh"
// Overview of operation
// - Four address, eight data, strobes, reset, aux.
// - Direction register bit one makes line output.
// - Hard reset leaves aux lines undriven inputs.
// - Level register returns actual pin levels.
// - Inversion per line for wake polarity.
// - Inversion never touches the suspend output.
// - Alternate register enables address and suspend.
// - Serial port bit takes four pins.
// - Aux 1 and 0 become address 5, 4.
// - Aux 2 carries suspend when enabled.
// - Monitor register picks wake source lines.
// - Polarity register one wakes on high.
// - Address pins 3:2 at reset pick mode.
// - Address 0, 1 give identifier and power.
// - Data pins give vendor identifier.
// - Memory address pins give product identifier.
// - Memory pins carry parallel port strobes, data.
// - External ROM mode uses aux 6 select.
// - Aux 5 outputs audio feedback comparison.
// - Upper address space strobes peripheral bus.
// - Strap bit picks suspend output polarity.
module pbal_aux_lines (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [7:0] regAddr,
	input wire logic regRead,
	input wire logic regWrite,
	input wire logic [7:0] regWdata,
	input wire logic [1:0] pulseSel,
	output logic [7:0] regRdata,
	output logic regReady,
	output logic regBusy,
	input wire logic [6:0] auxIn,
	output logic [6:0] auxOut,
	output logic [6:0] auxOeN,
	input wire logic [3:0] periphAddrIn,
	output logic [3:0] periphAddrOut,
	output logic [3:0] periphAddrOeN,
	input wire logic [7:0] periphDataIn,
	output logic [7:0] periphDataOut,
	output logic [7:0] periphDataOeN,
	output logic periphReadN,
	output logic periphWriteN,
	output logic periphResetOutN,
	input wire logic [14:0] memAddrPinsIn,
	output logic [14:0] memAddrPinsOut,
	output logic [14:0] memAddrPinsOeN,
	input wire logic [7:0] memDataIn,
	output logic [7:0] memDataOut,
	output logic [7:0] memDataOeN,
	input wire logic usbSuspend,
	input wire logic audioCompare,
	input wire logic upifSerialOut,
	output logic upifSerialIn,
	output logic upifSelectN,
	output logic upifSerialClk,
	input wire logic bootRomSelect,
	input wire logic [10:0] bootRomAddr,
	output logic [7:0] bootRomData,
	input wire logic portWriteN,
	input wire logic portReadN,
	input wire logic [7:0] portDataOut,
	output logic wakeRequest,
	output logic strapDone,
	output logic [1:0] chipMode,
	output logic [15:0] productId,
	output logic [15:0] vendorId,
	output logic selfPowered
);
	// ----------------------------------------
	// Pin synchronisers and strap capture.
	// ----------------------------------------
	logic [41:0] pinSync;
	logic [6:0] auxSync;
	logic [3:0] haSync;
	logic [7:0] hdSync;
	logic [14:0] sadSync;
	logic [7:0] sdaSync;

	pbal_sync #(.W(42)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.din({auxIn, periphAddrIn, periphDataIn, memAddrPinsIn, memDataIn}),
		.dout(pinSync)
	);

	assign auxSync = pinSync[41:35];
	assign haSync = pinSync[34:31];
	assign hdSync = pinSync[30:23];
	assign sadSync = pinSync[22:8];
	assign sdaSync = pinSync[7:0];
	pbal_strap_if strap ();
	pbal_strap u_strap (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.haIn(haSync),
		.hdIn(hdSync),
		.sadIn(sadSync),
		.sdaIn(sdaSync),
		.strap(strap.prod)
	);

	assign strapDone = strap.done;
	assign chipMode = strap.mode;
	assign productId = strap.productId;
	assign vendorId = strap.vendorId;
	assign selfPowered = strap.selfPowered;

	// ----------------------------------------
	// Address decode.
	// ----------------------------------------
	function automatic logic isPeriph(input logic [7:0] a);
		isPeriph = (a[7:6] == `PBAL_PERIPH_SPACE);
	endfunction : isPeriph
	function automatic logic [4:0] pulseCycles(input logic [1:0] sel);
		case (sel)
			2'h0: pulseCycles = `PBAL_PULSE_SEL0;
			2'h1: pulseCycles = `PBAL_PULSE_SEL1;
			2'h2: pulseCycles = `PBAL_PULSE_SEL2;
			default: pulseCycles = `PBAL_PULSE_SEL3;
		endcase
	endfunction : pulseCycles
	logic [7:0] altFunc_q;
	logic [7:0] auxDir_q;
	logic [7:0] wakePol_q;
	logic [7:0] wakeMon_q;
	logic [7:0] auxOutVal_q;
	logic [7:0] spiCfg_q;
	pbal_pkg::pbal_bus_state_t state_q;
	pbal_pkg::pbal_bus_state_t state_d;
	logic [4:0] cnt_q;
	logic [5:0] addrLatch_q;
	logic [7:0] wdLatch_q;
	logic isWrite_q;
	wire idle = (state_q == pbal_pkg::PBAL_BUS_IDLE);
	wire intRead = regRead && !isPeriph(regAddr);
	wire intWrite = regWrite && !isPeriph(regAddr);
	wire perReq = (regRead || regWrite) && isPeriph(regAddr) && idle && strap.done;
	wire strobeEnd = (state_q == pbal_pkg::PBAL_BUS_STROBE) && (cnt_q == 5'h01);
	// ----------------------------------------
	// Register file.
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			altFunc_q <= `PBAL_REG_RESET;
			auxDir_q <= `PBAL_REG_RESET;
			wakePol_q <= `PBAL_REG_RESET;
			wakeMon_q <= `PBAL_REG_RESET;
			auxOutVal_q <= `PBAL_REG_RESET;
			spiCfg_q <= `PBAL_REG_RESET;
		end else if (ce && intWrite) begin
			case (regAddr)
				`PBAL_REG_ALT_FUNC: altFunc_q <= regWdata;
				`PBAL_REG_AUX_DIR: auxDir_q <= regWdata;
				`PBAL_REG_WAKE_POL: wakePol_q <= regWdata;
				`PBAL_REG_WAKE_MON: wakeMon_q <= regWdata;
				`PBAL_REG_AUX_OUT: auxOutVal_q <= regWdata;
				`PBAL_REG_SPI_CFG: spiCfg_q <= regWdata;
				default: ;
			endcase
		end
	end

	wire [7:0] readMux =
		(regAddr == `PBAL_REG_ALT_FUNC) ? altFunc_q :
		(regAddr == `PBAL_REG_AUX_LEVEL) ? {1'b0, auxSync} :
		(regAddr == `PBAL_REG_AUX_DIR) ? auxDir_q :
		(regAddr == `PBAL_REG_WAKE_POL) ? wakePol_q :
		(regAddr == `PBAL_REG_WAKE_MON) ? wakeMon_q :
		(regAddr == `PBAL_REG_AUX_OUT) ? auxOutVal_q :
		(regAddr == `PBAL_REG_SPI_CFG) ? spiCfg_q : 8'h00;

	// ----------------------------------------
	// Peripheral bus cycle.
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			pbal_pkg::PBAL_BUS_IDLE: begin
				if (perReq) begin
					state_d = pbal_pkg::PBAL_BUS_STROBE;
				end
			end
			pbal_pkg::PBAL_BUS_STROBE: begin
				if (strobeEnd) begin
					state_d = pbal_pkg::PBAL_BUS_DONE;
				end
			end
			default: state_d = pbal_pkg::PBAL_BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= pbal_pkg::PBAL_BUS_IDLE;
			cnt_q <= 5'h00;
			addrLatch_q <= 6'h00;
			wdLatch_q <= 8'h00;
			isWrite_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			if (perReq) begin
				cnt_q <= pulseCycles(pulseSel);
				addrLatch_q <= regAddr[5:0];
				wdLatch_q <= regWdata;
				isWrite_q <= regWrite;
			end else if (cnt_q != 5'h00) begin
				cnt_q <= cnt_q - 5'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			periphReadN <= 1'b1;
			periphWriteN <= 1'b1;
			regReady <= 1'b0;
			regRdata <= 8'h00;
		end else if (ce) begin
			if (perReq) begin
				periphReadN <= regWrite;
				periphWriteN <= !regWrite;
			end else if (strobeEnd) begin
				periphReadN <= 1'b1;
				periphWriteN <= 1'b1;
			end
			regReady <= strobeEnd || ((intRead || intWrite) && !perReq);
			if (strobeEnd && !isWrite_q) begin
				regRdata <= hdSync;
			end else if (intRead) begin
				regRdata <= readMux;
			end
		end
	end

	assign regBusy = !idle;

	// ----------------------------------------
	// Aux line drive selection.
	// ----------------------------------------
	wire spiEn = spiCfg_q[`PBAL_SPI_EN_BIT];
	wire haExt = altFunc_q[`PBAL_ALT_HA_BIT] && !spiEn;
	wire suspEn = altFunc_q[`PBAL_ALT_SUSP_BIT];
	wire fbEn = altFunc_q[`PBAL_ALT_FB_BIT];
	wire romMode = (strap.mode == pbal_pkg::PBAL_MODE_EXTROM);
	// Suspend polarity comes only from its strap, so the wake inversion cannot flip it.
	wire suspLevel = strap.productId[5] ? usbSuspend : !usbSuspend;

	wire [6:0] auxDrive = {
		romMode || auxDir_q[6],
		fbEn || auxDir_q[5],
		auxDir_q[4:3],
		suspEn || auxDir_q[2],
		spiEn || haExt || auxDir_q[1],
		!spiEn && (haExt || auxDir_q[0])
	};
	wire [6:0] auxValue = {
		romMode ? !bootRomSelect : auxOutVal_q[6],
		fbEn ? audioCompare : auxOutVal_q[5],
		auxOutVal_q[4:3],
		suspEn ? suspLevel : auxOutVal_q[2],
		spiEn ? upifSerialOut : (haExt ? addrLatch_q[5] : auxOutVal_q[1]),
		haExt ? addrLatch_q[4] : auxOutVal_q[0]
	};

	// Every line waits for the strap capture before it drives.
	generate
		for (genvar i = 0; i < 7; i++) begin : g_aux
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					auxOut[i] <= 1'b0;
					auxOeN[i] <= 1'b1;
				end else if (ce) begin
					auxOut[i] <= auxValue[i];
					auxOeN[i] <= !(strap.done && auxDrive[i]);
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Bus, memory pin and wake outputs.
	// ----------------------------------------
	wire [6:0] wakeTerm = wakeMon_q[6:0] & ~(auxSync ^ wakePol_q[6:0]);
	wire memWrDrive = strap.done && !romMode && !portWriteN;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			periphAddrOut <= 4'h0;
			periphAddrOeN <= 4'hF;
			periphDataOut <= 8'h00;
			periphDataOeN <= 8'hFF;
			periphResetOutN <= 1'b0;
			memAddrPinsOut <= 15'h0000;
			memAddrPinsOeN <= 15'h7FFF;
			memDataOut <= 8'h00;
			memDataOeN <= 8'hFF;
			bootRomData <= 8'h00;
			wakeRequest <= 1'b0;
		end else if (ce) begin
			periphAddrOut <= addrLatch_q[3:0];
			periphAddrOeN <= {{2{spiEn}}, 2'b00} | {4{!strap.done}};
			periphDataOut <= wdLatch_q;
			periphDataOeN <= {8{!((state_q == pbal_pkg::PBAL_BUS_STROBE) && isWrite_q)}};
			periphResetOutN <= strap.done;
			memAddrPinsOut <= {portReadN, portWriteN, 2'b00, bootRomAddr};
			memAddrPinsOeN <= {15{!strap.done}};
			memDataOut <= portDataOut;
			memDataOeN <= {8{!memWrDrive}};
			bootRomData <= sdaSync;
			wakeRequest <= |wakeTerm;
		end
	end

	assign upifSerialIn = auxSync[0];
	assign upifSelectN = haSync[2];
	assign upifSerialClk = haSync[3];

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence sPerRead;
		perReq && !regWrite && pulseSel == 2'h0 && ce;
	endsequence
	sequence sStrobeTwo;
		(!periphReadN && ce) [*2] ##1 (periphReadN && regReady);
	endsequence

	a_float_reset: assert property (!strap.done |-> &auxOeN && &periphAddrOeN)
		else $error("Pins driven before strap capture.");
	a_dir_follow: assert property ($past(strap.done) && $past(ce)
		|-> auxOeN[3] == !$past(auxDir_q[3]))
		else $error("Aux 3 drive does not follow direction bit.");
	a_level_read: assert property (intRead && regAddr == `PBAL_REG_AUX_LEVEL && ce
		|=> regRdata == {1'b0, $past(auxSync)} && regReady)
		else $error("Level read does not show pin levels.");
	a_wake_none: assert property ($past(wakeMon_q) == 8'h00 && $past(ce)
		|-> !wakeRequest)
		else $error("Wake raised with no line monitored.");
	a_wake_low: assert property (wakeMon_q[0] && !wakePol_q[0] && !auxSync[0] && ce
		|=> wakeRequest)
		else $error("Low monitored line did not wake.");
	a_spi_pins: assert property (strap.done && spiEn && ce
		|=> auxOeN[0] && !auxOeN[1] && periphAddrOeN[3:2] == 2'b11)
		else $error("Serial port pin directions wrong.");
	a_susp_pol: assert property (strap.done && suspEn && ce
		|=> !auxOeN[2] && auxOut[2] == (strap.productId[5] ~^ $past(usbSuspend)))
		else $error("Suspend output level or drive wrong.");
	a_ha_ext: assert property (strap.done && haExt && ce
		|=> auxOut[1:0] == $past(addrLatch_q[5:4]) && auxOeN[1:0] == 2'b00)
		else $error("Aux 1 and 0 do not carry address 5 and 4.");
	a_per_strobe: assert property (sPerRead |=> sStrobeTwo)
		else $error("Peripheral read strobe width wrong.");
	a_per_addr: assert property (perReq && ce |=> ##1 periphAddrOut == $past(regAddr[3:0], 2))
		else $error("Peripheral address not placed on pins.");
endmodule : pbal_aux_lines

// File: hw/pbal_pkg.sv
package pbal_pkg;

	typedef enum logic [1:0] {
		PBAL_MODE_LEGACY = 2'b00,
		PBAL_MODE_NEWTAB = 2'b01,
		PBAL_MODE_TEST = 2'b10,
		PBAL_MODE_EXTROM = 2'b11
	} pbal_mode_t;

	typedef enum logic [1:0] {
		PBAL_BUS_IDLE = 2'b00,
		PBAL_BUS_STROBE = 2'b01,
		PBAL_BUS_DONE = 2'b10
	} pbal_bus_state_t;

	typedef logic [15:0] pbal_id_t;

endpackage : pbal_pkg

// File: hw/pbal_regs.svh
`ifndef PBAL_REGS_SVH
`define PBAL_REGS_SVH

// ----------------------------------------
// Register offsets on the internal bus.
// ----------------------------------------
`define PBAL_REG_ALT_FUNC 8'h00
`define PBAL_REG_AUX_LEVEL 8'h12
`define PBAL_REG_AUX_DIR 8'h13
`define PBAL_REG_WAKE_POL 8'h14
`define PBAL_REG_WAKE_MON 8'h15
`define PBAL_REG_AUX_OUT 8'h16
`define PBAL_REG_SPI_CFG 8'h29

// ----------------------------------------
// Field positions.
// ----------------------------------------
`define PBAL_ALT_HA_BIT 0
`define PBAL_ALT_SUSP_BIT 1
`define PBAL_ALT_FB_BIT 2
`define PBAL_SPI_EN_BIT 5
`define PBAL_PERIPH_SPACE 2'h3

// ----------------------------------------
// Reset values and timing counts.
// ----------------------------------------
`define PBAL_REG_RESET 8'h00
`define PBAL_STRAP_SETTLE 3'h4
`define PBAL_PULSE_SEL0 5'h02
`define PBAL_PULSE_SEL1 5'h03
`define PBAL_PULSE_SEL2 5'h08
`define PBAL_PULSE_SEL3 5'h10

`endif

// File: hw/pbal_strap.sv
`timescale 1ns/1ns
`include "pbal_regs.svh"
module pbal_strap (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [3:0] haIn,
	input wire logic [7:0] hdIn,
	input wire logic [14:0] sadIn,
	input wire logic [7:0] sdaIn,
	pbal_strap_if.prod strap
);
	logic [2:0] cnt_q;
	logic done_q;
	logic take;
	pbal_pkg::pbal_mode_t mode_q;
	pbal_pkg::pbal_id_t pid_q;
	pbal_pkg::pbal_id_t vid_q;
	logic self_q;

	// Waiting out the synchroniser keeps stale reset-time zeros out of the straps.
	assign take = !done_q && (cnt_q == `PBAL_STRAP_SETTLE);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 3'h0;
			done_q <= 1'b0;
		end else if (ce && !done_q) begin
			cnt_q <= cnt_q + 3'h1;
			done_q <= take;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= pbal_pkg::PBAL_MODE_LEGACY;
			pid_q <= 16'h0000;
			vid_q <= 16'h0000;
			self_q <= 1'b0;
		end else if (ce && take) begin
			mode_q <= pbal_pkg::pbal_mode_t'(haIn[3:2]);
			pid_q <= {haIn[0], sadIn};
			self_q <= haIn[1];
			vid_q <= {hdIn, sdaIn};
		end
	end

	assign strap.done = done_q;
	assign strap.mode = mode_q;
	assign strap.productId = pid_q;
	assign strap.vendorId = vid_q;
	assign strap.selfPowered = self_q;

	a_mode_capture: assert property (@(posedge clk) disable iff (!resetn)
		$rose(done_q) |-> mode_q == pbal_pkg::pbal_mode_t'($past(haIn[3:2])))
		else $error("Chip mode not taken from address pins 3 and 2.");
	a_id_capture: assert property (@(posedge clk) disable iff (!resetn)
		$rose(done_q) |-> pid_q == {$past(haIn[0]), $past(sadIn)}
			&& vid_q == {$past(hdIn), $past(sdaIn)})
		else $error("Identifier straps captured wrongly.");
endmodule : pbal_strap

// File: hw/pbal_strap_if.sv
`timescale 1ns/1ns
interface pbal_strap_if;
	logic done;
	pbal_pkg::pbal_mode_t mode;
	pbal_pkg::pbal_id_t productId;
	pbal_pkg::pbal_id_t vendorId;
	logic selfPowered;

	modport prod (output done, output mode, output productId, output vendorId, output selfPowered);
	modport cons (input done, input mode, input productId, input vendorId, input selfPowered);
endinterface : pbal_strap_if

// File: hw/pbal_sync.sv
`timescale 1ns/1ns
module pbal_sync #(
	parameter int W = 42
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			dout <= '0;
		end else if (ce) begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : pbal_sync

// File: tb/pbal_aux_lines_tb.sv
`timescale 1ns/1ns
module pbal_aux_lines_tb;
	logic clk, resetn, ce, regRead, regWrite, regReady, regBusy, periphReadN, periphWriteN;
	logic periphResetOutN, usbSuspend, audioCompare, upifSerialOut, upifSerialIn, upifSelectN;
	logic upifSerialClk, bootRomSelect, portWriteN, portReadN, wakeRequest, strapDone, selfPowered;
	logic [7:0] regAddr, regWdata, regRdata, periphDataOut, periphDataOeN, memDataOut, memDataOeN;
	logic [7:0] bootRomData, portDataOut, pDataPin, memDPin, sdaStrap, hdStrap, q, d, e;
	logic [6:0] auxOut, auxOeN, auxExt, auxPin;
	logic [3:0] periphAddrOut, periphAddrOeN, pAddrPin, haStrap;
	logic [14:0] memAddrPinsOut, memAddrPinsOeN, memAPin, sadStrap;
	logic [15:0] productId, vendorId;
	logic [10:0] bootRomAddr;
	logic [1:0] pulseSel, chipMode, lastHi;
	logic [31:0] rndState;
	int errors, n_checks, cycles, strobeCnt;
	assign auxPin = (~auxOeN & auxOut) | (auxOeN & auxExt);
	assign memAPin = (~memAddrPinsOeN & memAddrPinsOut) | (memAddrPinsOeN & sadStrap);
	assign memDPin = (~memDataOeN & memDataOut) | (memDataOeN & sdaStrap);
	pbal_aux_lines u_dut (.clk, .resetn, .ce, .regAddr, .regRead, .regWrite, .regWdata,
		.pulseSel, .regRdata, .regReady, .regBusy, .auxIn(auxPin), .auxOut, .auxOeN,
		.periphAddrIn(pAddrPin), .periphAddrOut, .periphAddrOeN, .periphDataIn(pDataPin),
		.periphDataOut, .periphDataOeN, .periphReadN, .periphWriteN, .periphResetOutN,
		.memAddrPinsIn(memAPin), .memAddrPinsOut, .memAddrPinsOeN, .memDataIn(memDPin),
		.memDataOut, .memDataOeN, .usbSuspend, .audioCompare, .upifSerialOut, .upifSerialIn,
		.upifSelectN, .upifSerialClk, .bootRomSelect, .bootRomAddr, .bootRomData, .portWriteN,
		.portReadN, .portDataOut, .wakeRequest, .strapDone, .chipMode, .productId, .vendorId,
		.selfPowered);
	pbal_periph_model u_periph (.addrOut(periphAddrOut), .addrOeN(periphAddrOeN),
		.dataOut(periphDataOut), .dataOeN(periphDataOeN), .readN(periphReadN),
		.writeN(periphWriteN), .resetOutN(periphResetOutN), .addrStrap(haStrap),
		.dataStrap(hdStrap), .addrPin(pAddrPin), .dataPin(pDataPin));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// Helpers.
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		rndState ^= rndState << 13;
		rndState ^= rndState >> 17;
		rndState ^= rndState << 5;
		return rndState[7:0];
	endfunction : rnd
	function automatic logic [15:0] widthOf(input logic [1:0] s);
		return (s == 2'h0) ? 16'h0002 : (s == 2'h1) ? 16'h0003 : (s == 2'h2) ? 16'h0008 : 16'h0010;
	endfunction : widthOf
	// A line wakes when monitored and its level, after the polarity flip, is low.
	function automatic logic wakeOf(input logic [6:0] m, input logic [6:0] p, input logic [6:0] l);
		return |(m & ~(l ^ p));
	endfunction : wakeOf
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic waitN(input int n);
		repeat (n) @(negedge clk);
	endtask : waitN
	task automatic regAcc(input logic wr, input logic [7:0] a, input logic [7:0] dv);
		@(negedge clk);
		regAddr = a;
		regWdata = dv;
		regRead = !wr;
		regWrite = wr;
		@(negedge clk);
		regRead = 1'b0;
		regWrite = 1'b0;
		for (int i = 0; i < 40 && regReady !== 1'b1; i++) @(negedge clk);
		chk("regReady", 16'h1, {15'h0, regReady});
		q = regRdata;
	endtask : regAcc
	task automatic done(input string name);
		$display("Test %s finished", name);
	endtask : done
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	always @(negedge clk) begin
		if (periphReadN === 1'b0 || periphWriteN === 1'b0) begin
			strobeCnt++;
			lastHi = auxOut[1:0] | auxOeN[1:0];
		end
	end
	// The whole sequence needs about five hundred cycles; a hang is cut well beyond that.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial begin
		rndState = 32'd20;
		{resetn, ce, regRead, regWrite, regAddr, regWdata, pulseSel} = '0;
		{usbSuspend, audioCompare, upifSerialOut, bootRomSelect, bootRomAddr} = '0;
		{portWriteN, portReadN, portDataOut, auxExt} = {2'b11, rnd(), 7'(rnd())};
		haStrap = {2'b01, 2'(rnd())};
		{hdStrap, sdaStrap, sadStrap} = 31'({rnd(), rnd(), rnd(), rnd()});
		ce = 1'b1;
		waitN(20);
		chk("auxOeN reset", 16'h007F, {9'h0, auxOeN});
		chk("dataOeN reset", 16'h00FF, {8'h0, periphDataOeN});
		chk("periph reset", 16'h0, {15'h0, periphResetOutN});
		resetn = 1'b1;
		for (int i = 0; i < 20 && strapDone !== 1'b1; i++) @(negedge clk);
		waitN(3);
		chk("chipMode", {14'h0, haStrap[3:2]}, {14'h0, chipMode});
		chk("productId", {haStrap[0], sadStrap}, productId);
		chk("vendorId", {hdStrap, sdaStrap}, vendorId);
		chk("selfPowered", {15'h0, haStrap[1]}, {15'h0, selfPowered});
		chk("periph reset", 16'h1, {15'h0, periphResetOutN});
		chk("rom data", {8'h0, sdaStrap}, {8'h0, bootRomData});
		done("strap");
		regAcc(1'b0, 8'h13, 8'h00);
		chk("dir reset", 16'h0, {8'h0, q});
		for (int k = 0; k < 6; k++) begin
			e = (k == 0) ? 8'h00 : (k == 1) ? 8'h13 : (k == 2) ? 8'h14 : (k == 3) ? 8'h15 :
				(k == 4) ? 8'h16 : 8'h29;
			d = rnd() & 8'h7F;
			d[4] = d[3];
			regAcc(1'b1, e, d);
			regAcc(1'b0, e, 8'h00);
			chk("reg readback", {8'h0, d}, {8'h0, q});
		end
		regAcc(1'b0, 8'h40, 8'h00);
		chk("unmapped read", 16'h0, {8'h0, q});
		regAcc(1'b1, 8'h00, 8'h00);
		regAcc(1'b1, 8'h29, 8'h00);
		done("registers");
		for (int k = 0; k < 8; k++) begin
			d = (k == 0) ? 8'h7F : (k == 1) ? 8'h00 : rnd() & 8'h7F;
			d[4] = d[3];
			e = rnd();
			auxExt = 7'(rnd());
			regAcc(1'b1, 8'h13, d);
			regAcc(1'b1, 8'h16, e);
			waitN(4);
			chk("auxOeN", {9'h0, ~d[6:0]}, {9'h0, auxOeN});
			regAcc(1'b0, 8'h12, 8'h00);
			chk("aux level", {9'h0, (d[6:0] & e[6:0]) | (~d[6:0] & auxExt)}, {8'h0, q});
		end
		done("direction");
		regAcc(1'b1, 8'h13, 8'h00);
		for (int k = 0; k < 8; k++) begin
			d = rnd();
			e = (k == 0) ? 8'h00 : rnd();
			auxExt = 7'(rnd());
			regAcc(1'b1, 8'h14, d);
			regAcc(1'b1, 8'h15, e);
			waitN(5);
			chk("wake", {15'h0, wakeOf(e[6:0], d[6:0], auxExt)}, {15'h0, wakeRequest});
		end
		regAcc(1'b1, 8'h14, 8'h00);
		regAcc(1'b1, 8'h15, 8'h7F);
		auxExt = 7'h7F;
		waitN(5);
		ce = 1'b0;
		auxExt = 7'h00;
		waitN(5);
		chk("frozen wake", 16'h0, {15'h0, wakeRequest});
		ce = 1'b1;
		waitN(5);
		chk("wake after freeze", 16'h1, {15'h0, wakeRequest});
		done("wake");
		regAcc(1'b1, 8'h00, 8'h02);
		for (int s = 0; s < 2; s++) begin
			usbSuspend = s[0];
			regAcc(1'b1, 8'h15, rnd());
			waitN(4);
			chk("suspend", {15'h0, sadStrap[5] ~^ s[0]}, {15'h0, auxPin[2]});
		end
		regAcc(1'b1, 8'h00, 8'h04);
		for (int s = 0; s < 2; s++) begin
			audioCompare = s[0];
			waitN(4);
			chk("feedback", {15'h0, s[0]}, {15'h0, auxPin[5]});
		end
		regAcc(1'b1, 8'h00, 8'h00);
		regAcc(1'b1, 8'h29, 8'h20);
		for (int s = 0; s < 4; s++) begin
			auxExt[0] = s[0];
			upifSerialOut = s[1];
			// The serial master drives select and clock once the pins are released.
			haStrap[2] = s[1];
			haStrap[3] = s[0];
			waitN(5);
			chk("serial in", {15'h0, s[0]}, {15'h0, upifSerialIn});
			chk("serial select", {15'h0, s[1]}, {15'h0, upifSelectN});
			chk("serial clock", {15'h0, s[0]}, {15'h0, upifSerialClk});
			chk("serial out", {15'h0, s[1]}, {15'h0, auxPin[1]});
		end
		regAcc(1'b1, 8'h29, 8'h00);
		done("alternate");
		for (int s = 0; s < 4; s++) begin
			pulseSel = s[1:0];
			strobeCnt = 0;
			regAcc(1'b1, 8'hC0 + 8'(s * 5), 8'h30 + 8'(s));
			chk("strobe width", widthOf(s[1:0]), 16'(strobeCnt));
			chk("busy", 16'h1, {15'h0, regBusy});
			strobeCnt = 0;
			regAcc(1'b0, 8'hC0, 8'h00);
			chk("read strobe", widthOf(s[1:0]), 16'(strobeCnt));
		end
		pulseSel = 2'h3;
		for (int s = 0; s < 4; s++) begin
			regAcc(1'b0, 8'hC0 + 8'(s * 5), 8'h00);
			chk("periph read", 16'h0030 + 16'(s), {8'h0, q});
		end
		regAcc(1'b1, 8'h00, 8'h01);
		regAcc(1'b1, 8'hE5, rnd());
		chk("high address", 16'h2, {14'h0, lastHi});
		done("peripheral");
		portDataOut = rnd();
		bootRomAddr = {3'h5, rnd()};
		portWriteN = 1'b0;
		portReadN = 1'b0;
		waitN(4);
		chk("port write", 16'h0, {15'h0, memAPin[13]});
		chk("port data", {8'h0, portDataOut}, {8'h0, memDPin});
		chk("port read", 16'h0, {15'h0, memAPin[14]});
		chk("rom addr", {5'h0, bootRomAddr}, {5'h0, memAPin[10:0]});
		portWriteN = 1'b1;
		portReadN = 1'b1;
		done("parallel");
		haStrap = 4'hC;
		resetn = 1'b0;
		waitN(3);
		chk("auxOeN rerun", 16'h007F, {9'h0, auxOeN});
		resetn = 1'b1;
		waitN(12);
		chk("rom mode", 16'h0003, {14'h0, chipMode});
		portWriteN = 1'b0;
		for (int s = 0; s < 2; s++) begin
			bootRomSelect = s[0];
			waitN(2);
			chk("rom select", {15'h0, !s[0]}, {15'h0, auxPin[6]});
			chk("rom data pins", 16'h00FF, {8'h0, memDataOeN});
		end
		portWriteN = 1'b1;
		done("rom");
		end_of_test();
	end
endmodule : pbal_aux_lines_tb

// File: tb/pbal_periph_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Peripheral chip on the byte-wide bus.
// ----------------------------------------
module pbal_periph_model (
	input wire logic [3:0] addrOut,
	input wire logic [3:0] addrOeN,
	input wire logic [7:0] dataOut,
	input wire logic [7:0] dataOeN,
	input wire logic readN,
	input wire logic writeN,
	input wire logic resetOutN,
	input wire logic [3:0] addrStrap,
	input wire logic [7:0] dataStrap,
	output logic [3:0] addrPin,
	output logic [7:0] dataPin
);
	logic [7:0] mem [16];
	logic [7:0] rdVal;
	logic [7:0] wrData;
	logic [3:0] wrAddr;
	logic drive;
	// Pull resistors hold the strap levels on any line that nobody drives.
	assign addrPin = (~addrOeN & addrOut) | (addrOeN & addrStrap);
	// The chip answers only once out of its own reset and only while read is low.
	assign drive = ~readN & resetOutN;
	assign rdVal = drive ? mem[addrPin] : dataStrap;
	assign dataPin = (~dataOeN & dataOut) | (dataOeN & rdVal);
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 8'hA5 ^ 8'(i);
		end
	end
	// Data is latched while driven, so a release at the strobe edge cannot race it.
	always @* begin
		if (!writeN && dataOeN == 8'h00) begin
			wrData = dataPin;
			wrAddr = addrPin;
		end
	end
	always @(posedge writeN) begin
		if (resetOutN) begin
			mem[wrAddr] <= wrData;
		end
	end
endmodule : pbal_periph_model
